/* hw/ptirq_pkg.sv */
// Overview of operation
// - Over-current enable bit 7 switches the supply-output pin detector on or off.
// - Edge-select bit 7 set: latch falling edges only, held until reset or service.
// - Edge-select bit clear: a low level on the interrupt pin requests an interrupt.
// - Edge-select takes only the first write in normal mode, any write in special.
// - Pin-enable bit 6 connects the interrupt pin; writable at any time.
// - Factory-test register takes writes only in special mode.
// - General-purpose output with no alternate owner drives the stored data bit.
// - Data read returns stored bit when direction is 1, else synchronized pin.
// - On pins 3 and 2 an enabled serial-peripheral function beats all others.
// - On pins 3 and 2 an enabled transceiver channel beats timer and general use.
// - On pin 1 async serial or the direct-drive bit beats timer and general use.
// - On pin 0 async serial beats timer output and general use.
// - On pins 1 and 0 an enabled timer beats general use.
// - PWM reaches a pin only when no driver function is routed there.
// - Timer compare reaches a pin only when no driver function is routed there.
// - Timer capture sees a pin only when it is not the transceiver receive pin.
// - Input register bits 3 to 0 always read the synchronized pin state.
// - Input register is always readable and ignores writes.
// - Direction 1 makes a pin an output, 0 an input.
// - A peripheral forcing direction leaves the stored direction bit untouched.
// - Register reads see pins only after synchronization to the bus clock.
package ptirq_pkg;
  // Register offsets
  localparam logic [2:0] OFS_MISC_CONTROL = 3'h0;
  localparam logic [2:0] OFS_IRQ_PIN_CONTROL = 3'h1;
  localparam logic [2:0] OFS_FACTORY_TEST_RESERVED = 3'h2;
  localparam logic [2:0] OFS_PORT_T_DATA = 3'h3;
  localparam logic [2:0] OFS_PORT_T_INPUT = 3'h4;
  // Field positions
  localparam int BIT_OVERCURRENT_ENABLE = 7;
  localparam int BIT_IRQ_EDGE_SELECT = 7;
  localparam int BIT_IRQ_PIN_ENABLE = 6;
  // Reset values
  localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_PIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_FACTORY_TEST = 8'h00;
  localparam logic [3:0] RST_PORT_T_DATA = 4'h0;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // Which pins can carry each alternate function
  localparam logic [3:0] PINS_SPI = 4'hC;
  localparam logic [3:0] PINS_PHY = 4'hC;
  localparam logic [3:0] PINS_SCI = 4'h3;
  localparam logic [3:0] PINS_PHY_OUT = 4'h4;
  localparam int PIN_PHY_DIRECT = 1;
  // Synchronizer depth and port width
  localparam int SYNC_STAGES = 3;
  localparam int PORT_PINS = 4;
endpackage : ptirq_pkg

/* hw/ptirq_sync_if.sv */
`timescale 1ns/10ps
// Raw pin levels in, filtered synchronized levels out
interface ptirq_sync_if #(
  parameter int WIDTH = 5
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : ptirq_sync_if

/* hw/ptirq_sync.sv */
`timescale 1ns/10ps
module ptirq_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Pin levels
  ptirq_sync_if.sync sif
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } ptirq_sync_st_t;

  ptirq_sync_st_t st_reg;
  ptirq_sync_st_t st_next;

  if (WIDTH < 1) begin : g_chk
    $error("ptirq_sync needs at least one bit");
  end

  // Three-stage chain; a level counts once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = sif.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.filt[i] = st_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.level = st_reg.filt;
endmodule : ptirq_sync

/* hw/ptirq_irq.sv */
`timescale 1ns/10ps
module ptirq_irq (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Synchronized pin level, active low
  input wire logic pin_level,
  // Control bits
  input wire logic edge_select,
  input wire logic pin_enable,
  input wire logic service,
  // Request
  output logic request
);
  typedef struct packed {
    logic prev;
    logic pending;
    logic req;
  } ptirq_irq_st_t;

  ptirq_irq_st_t st_reg;
  ptirq_irq_st_t st_next;
  logic fall;

  // Falling edge latch, set beats service clear; low-level mode passes through
  always_comb begin
    st_next = st_reg;
    fall = st_reg.prev & ~pin_level & pin_enable;
    st_next.prev = pin_level;
    if (fall && edge_select) begin
      st_next.pending = 1'b1;
    end else if (service || !edge_select) begin
      st_next.pending = 1'b0;
    end
    if (!pin_enable) begin
      st_next.req = 1'b0;
    end else if (edge_select) begin
      st_next.req = st_next.pending;
    end else begin
      st_next.req = ~pin_level;
    end
  end

  // State register; pin idles high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= 3'h4;
    end else begin
      st_reg <= st_next;
    end
  end

  assign request = st_reg.req;
endmodule : ptirq_irq

/* hw/ptirq_port.sv */
`timescale 1ns/10ps
module ptirq_port #(
  parameter int ADDR_W = 3,
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Mode
  input wire logic special_mode,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Direction bits from the direction register
  input wire logic [3:0] port_direction_bits,
  // Package pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  // Interrupt pin and service
  input wire logic irq_pin_n,
  input wire logic irq_service,
  output logic irq_request,
  // Over-current detector on the supply-output pin
  output logic overcurrent_enable,
  // Factory test control
  output logic [7:0] factory_test,
  // Serial peripheral interface, pins 3 and 2
  input wire logic [3:0] spi_en,
  input wire logic [3:0] spi_oe,
  input wire logic [3:0] spi_out,
  // Physical-layer transceiver, pins 3 and 2 plus direct drive on pin 1
  input wire logic [3:0] phy_en,
  input wire logic phy_receive_signal,
  input wire logic phy_direct_drive_en,
  input wire logic phy_direct_drive_bit,
  input wire logic [3:0] phy_rx_route,
  // Async serial 0, pins 1 and 0
  input wire logic [3:0] sci_en,
  input wire logic [3:0] sci_oe,
  input wire logic [3:0] sci_out,
  // Timer module
  input wire logic [3:0] tim_oc_en,
  input wire logic [3:0] tim_out,
  output logic [3:0] tim_capture,
  // PWM
  input wire logic [3:0] pwm_en,
  input wire logic [3:0] pwm_out,
  // Pins routed to high-side or low-side driver
  input wire logic [3:0] driver_route,
  // Synchronized pins for peripherals
  output logic [3:0] pin_sync
);
  typedef struct packed {
    logic ocp;
    logic edge_sel;
    logic irq_en;
    logic edge_locked;
    logic [7:0] test;
    logic [3:0] data;
    logic [7:0] rdata;
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] cap;
    logic [3:0] sync;
  } ptirq_port_st_t;

  ptirq_port_st_t st_reg;
  ptirq_port_st_t st_next;
  logic [4:0] levels;
  logic [3:0] pins_now;
  logic irq_level;
  logic [1:0] drv;

  if (ADDR_W < 3) begin : g_chk_addr
    $error("ptirq_port needs at least three address bits");
  end
  if (PINS != ptirq_pkg::PORT_PINS) begin : g_chk_pins
    $error("ptirq_port serves exactly four port pins");
  end

  // Pin and interrupt synchronizers
  ptirq_sync_if #(.WIDTH(5)) sif ();
  assign sif.raw = {~irq_pin_n, pin_in}; // Inverted so a cleared chain reads an idle-high pin
  assign levels = sif.level;
  assign pins_now = levels[3:0];
  assign irq_level = ~levels[4];

  ptirq_sync #(
    .WIDTH(5)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .sif(sif.sync)
  );

  // Interrupt pin logic
  ptirq_irq u_irq (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin_level(irq_level),
    .edge_select(st_reg.edge_sel),
    .pin_enable(st_reg.irq_en),
    .service(irq_service),
    .request(irq_request)
  );

  // Pin owner precedence: returns {oe, out} for pin idx
  function automatic logic [1:0] drive_pin(
    input int idx,
    input logic [3:0] dir,
    input logic [3:0] data,
    input logic [3:0] s_en,
    input logic [3:0] s_oe,
    input logic [3:0] s_out,
    input logic [3:0] p_en,
    input logic p_rx,
    input logic d_en,
    input logic d_bit,
    input logic [3:0] c_en,
    input logic [3:0] c_oe,
    input logic [3:0] c_out,
    input logic [3:0] t_en,
    input logic [3:0] t_out,
    input logic [3:0] w_en,
    input logic [3:0] w_out,
    input logic [3:0] route
  );
    logic [1:0] r;
    r = {dir[idx], data[idx]};
    if (ptirq_pkg::PINS_SPI[idx] && s_en[idx]) begin
      r = {s_oe[idx], s_out[idx]};
    end else if (ptirq_pkg::PINS_PHY[idx] && p_en[idx]) begin
      r = {ptirq_pkg::PINS_PHY_OUT[idx], p_rx};
    end else if (idx == ptirq_pkg::PIN_PHY_DIRECT && d_en) begin
      r = {1'b1, d_bit};
    end else if (ptirq_pkg::PINS_SCI[idx] && c_en[idx]) begin
      r = {c_oe[idx], c_out[idx]};
    end else if (t_en[idx] && !route[idx]) begin
      r = {1'b1, t_out[idx]};
    end else if (w_en[idx] && !route[idx]) begin
      r = {1'b1, w_out[idx]};
    end
    return r;
  endfunction : drive_pin

  // Register writes, pin muxing and read path
  always_comb begin
    st_next = st_reg;
    drv = 2'b00;
    if (reg_wr) begin
      case (reg_addr[2:0])
        ptirq_pkg::OFS_MISC_CONTROL: begin
          st_next.ocp = reg_wdata[ptirq_pkg::BIT_OVERCURRENT_ENABLE];
        end
        ptirq_pkg::OFS_IRQ_PIN_CONTROL: begin
          st_next.irq_en = reg_wdata[ptirq_pkg::BIT_IRQ_PIN_ENABLE];
          if (special_mode || !st_reg.edge_locked) begin
            st_next.edge_sel = reg_wdata[ptirq_pkg::BIT_IRQ_EDGE_SELECT];
          end
          if (!special_mode) begin
            st_next.edge_locked = 1'b1;
          end
        end
        ptirq_pkg::OFS_FACTORY_TEST_RESERVED: begin
          if (special_mode) begin
            st_next.test = reg_wdata;
          end
        end
        ptirq_pkg::OFS_PORT_T_DATA: begin
          st_next.data = reg_wdata[3:0];
        end
        default: begin
          st_next.data = st_reg.data;
        end
      endcase
    end
    // Effective direction lives only in oe; the direction bits are never written
    for (int i = 0; i < ptirq_pkg::PORT_PINS; i++) begin
      drv = drive_pin(i, port_direction_bits, st_reg.data, spi_en, spi_oe, spi_out,
                      phy_en, phy_receive_signal, phy_direct_drive_en,
                      phy_direct_drive_bit, sci_en, sci_oe, sci_out, tim_oc_en, tim_out,
                      pwm_en, pwm_out, driver_route);
      st_next.oe[i] = drv[1];
      st_next.out[i] = drv[0];
      st_next.cap[i] = pins_now[i] & ~phy_rx_route[i];
    end
    st_next.sync = pins_now;
    // Read data appear in the cycle after the strobe only
    st_next.rdata = ptirq_pkg::RDATA_UNMAPPED;
    if (reg_rd) begin
      case (reg_addr[2:0])
        ptirq_pkg::OFS_MISC_CONTROL: begin
          st_next.rdata[ptirq_pkg::BIT_OVERCURRENT_ENABLE] = st_reg.ocp;
        end
        ptirq_pkg::OFS_IRQ_PIN_CONTROL: begin
          st_next.rdata[ptirq_pkg::BIT_IRQ_EDGE_SELECT] = st_reg.edge_sel;
          st_next.rdata[ptirq_pkg::BIT_IRQ_PIN_ENABLE] = st_reg.irq_en;
        end
        ptirq_pkg::OFS_FACTORY_TEST_RESERVED: begin
          st_next.rdata = st_reg.test;
        end
        ptirq_pkg::OFS_PORT_T_DATA: begin
          st_next.rdata[3:0] = (port_direction_bits & st_reg.data) |
                               (~port_direction_bits & pins_now);
        end
        ptirq_pkg::OFS_PORT_T_INPUT: begin
          st_next.rdata[3:0] = pins_now;
        end
        default: begin
          st_next.rdata = ptirq_pkg::RDATA_UNMAPPED;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg.ocp <= ptirq_pkg::RST_MISC_CONTROL[ptirq_pkg::BIT_OVERCURRENT_ENABLE];
      st_reg.edge_sel <= ptirq_pkg::RST_IRQ_PIN_CONTROL[ptirq_pkg::BIT_IRQ_EDGE_SELECT];
      st_reg.irq_en <= ptirq_pkg::RST_IRQ_PIN_CONTROL[ptirq_pkg::BIT_IRQ_PIN_ENABLE];
      st_reg.edge_locked <= 1'b0;
      st_reg.test <= ptirq_pkg::RST_FACTORY_TEST;
      st_reg.data <= ptirq_pkg::RST_PORT_T_DATA;
      st_reg.rdata <= ptirq_pkg::RDATA_UNMAPPED;
      st_reg.out <= 4'h0;
      st_reg.oe <= 4'h0;
      st_reg.cap <= 4'h0;
      st_reg.sync <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign pin_out = st_reg.out;
  assign pin_oe = st_reg.oe;
  assign overcurrent_enable = st_reg.ocp;
  assign factory_test = st_reg.test;
  assign tim_capture = st_reg.cap;
  assign pin_sync = st_reg.sync;
endmodule : ptirq_port

/* test/ptirq_chk.sv */
`timescale 1ns/10ps
module ptirq_chk #(
  parameter int ADDR_W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic [3:0] port_direction_bits,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_sync,
  // Sources
  input wire logic [3:0] spi_en,
  input wire logic [3:0] phy_en,
  input wire logic phy_receive_signal,
  input wire logic phy_direct_drive_en,
  input wire logic phy_direct_drive_bit,
  input wire logic [3:0] phy_rx_route,
  input wire logic [3:0] sci_en,
  input wire logic [3:0] tim_oc_en,
  input wire logic [3:0] tim_out,
  input wire logic [3:0] tim_capture,
  input wire logic [3:0] pwm_en,
  input wire logic [3:0] driver_route,
  // Status
  input wire logic irq_request,
  input wire logic overcurrent_enable
);
  logic irq_en_reg;
  logic no_alt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Copy of the interrupt pin enable bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_en_reg <= 1'h0;
    end else if (reg_wr && reg_addr == 3'h1) begin
      irq_en_reg <= reg_wdata[6];
    end
  end
  // No source claims any pin
  assign no_alt = ~|{spi_en, phy_en, phy_direct_drive_en, sci_en, tim_oc_en, pwm_en};
  a_oc_write: assert property (
    reg_wr && reg_addr == 3'h0 |=> overcurrent_enable == $past(reg_wdata[7]))
    else $error("overcurrent enable wrong");
  a_input_read: assert property (
    (reg_rd && reg_addr == 3'h4 && $stable(pin_sync)) ##1 $stable(pin_sync) ##1
    $stable(pin_sync) |-> $past(reg_rdata) == {4'h0, pin_sync})
    else $error("input read wrong");
  a_data_read: assert property (
    (reg_wr && reg_addr == 3'h3) ##1 (reg_rd && reg_addr == 3'h3 && port_direction_bits == 4'hF)
    |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
    else $error("data read wrong");
  a_gpio_dir: assert property (no_alt |=> pin_oe == $past(port_direction_bits))
    else $error("direction not applied");
  a_phy_pin: assert property (
    !spi_en[2] && phy_en[2] |=> pin_oe[2] && pin_out[2] == $past(phy_receive_signal))
    else $error("transceiver pin wrong");
  a_direct_drive: assert property (
    phy_direct_drive_en |=> pin_oe[1] && pin_out[1] == $past(phy_direct_drive_bit))
    else $error("direct drive wrong");
  a_timer_pin: assert property (
    tim_oc_en[0] && !sci_en[0] && !driver_route[0] |=>
    pin_oe[0] && pin_out[0] == $past(tim_out[0]))
    else $error("timer pin wrong");
  a_route_block: assert property (
    driver_route[0] && !sci_en[0] |=> pin_oe[0] == $past(port_direction_bits[0]))
    else $error("routed pin not blocked");
  a_capture_gate: assert property (
    |phy_rx_route |=> (tim_capture & $past(phy_rx_route)) == 4'h0)
    else $error("capture not gated");
  a_irq_off: assert property (!irq_en_reg [*3] |-> !irq_request)
    else $error("request while disabled");
  c_irq: cover property (irq_request);
  c_route: cover property (driver_route[0] && tim_oc_en[0]);
  c_input: cover property (reg_rd && reg_addr == 3'h4);
endmodule : ptirq_chk

bind ptirq_port ptirq_chk #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .port_direction_bits, .pin_out, .pin_oe, .pin_sync, .spi_en, .phy_en,
  .phy_receive_signal, .phy_direct_drive_en, .phy_direct_drive_bit, .phy_rx_route,
  .sci_en, .tim_oc_en, .tim_out, .tim_capture, .pwm_en, .driver_route,
  .irq_request, .overcurrent_enable
);

/* test/ptirq_pins.sv */
`timescale 1ns/10ps
module ptirq_pins (
  // Block side
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  // Outside world
  input wire logic [3:0] ext_level,
  // Level seen by the block
  output logic [3:0] pin_in
);
  // A driven pin shows the block's level, any other the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : ptirq_pins

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
  logic sys_clk, srst, special_mode, reg_wr, reg_rd, irq_pin_n, irq_service, irq_request;
  logic phy_receive_signal, phy_direct_drive_en, phy_direct_drive_bit, overcurrent_enable;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, factory_test, en;
  logic [3:0] port_direction_bits, pin_in, pin_out, pin_oe, ext, spi_en, spi_oe, spi_out;
  logic [3:0] phy_en, phy_rx_route, sci_en, sci_oe, sci_out, tim_oc_en, tim_out, tim_capture;
  logic [3:0] pwm_en, pwm_out, driver_route, pin_sync;
  logic [19:0] rows [10];
  int errors, cmp_count;
  // Bits 7, 6, 4, 3 and 2 of en each claim all pins for one source; bit 5 is the direct-drive enable, bit 1 routes all pins
  assign spi_en = {4{en[7]}};
  assign phy_en = {4{en[6]}};
  assign phy_direct_drive_en = en[5];
  assign sci_en = {4{en[4]}};
  assign tim_oc_en = {4{en[3]}};
  assign pwm_en = {4{en[2]}};
  assign driver_route = {4{en[1]}};
  always #5 sys_clk = ~sys_clk;
  ptirq_port uut (
    .sys_clk, .srst, .special_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_direction_bits, .pin_in, .pin_out, .pin_oe, .irq_pin_n, .irq_service,
    .irq_request, .overcurrent_enable, .factory_test, .spi_en, .spi_oe, .spi_out, .phy_en,
    .phy_receive_signal, .phy_direct_drive_en, .phy_direct_drive_bit, .phy_rx_route,
    .sci_en, .sci_oe, .sci_out, .tim_oc_en, .tim_out, .tim_capture, .pwm_en, .pwm_out,
    .driver_route, .pin_sync
  );
  ptirq_pins u_pins (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  // Verdict and end of run
  task results;
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle, launched after a rising edge
  task bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : bus
  task idle(input int n);
    repeat (n) bus(1'h0, 1'h0, 3'h0, 8'h00);
  endtask : idle
  task wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'h1, 1'h0, a, d);
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task rd(input logic [2:0] a, input logic [7:0] exp);
    bus(1'h0, 1'h1, a, 8'h00);
    idle(1);
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    results();
  end
  // Rows: source enables, direction, expected enable, expected level
  initial begin
    sys_clk = 1'h0;
    {srst, special_mode, reg_wr, reg_rd, irq_pin_n, irq_service} = 6'h22;
    {phy_receive_signal, phy_direct_drive_bit} = 2'h0;
    {spi_oe, spi_out, sci_oe, sci_out, tim_out, pwm_out} = 24'h8C_315A;
    {en, port_direction_bits, ext, phy_rx_route, reg_addr, reg_wdata} = 31'h0000_0000;
    errors = 0;
    cmp_count = 0;
    rows = '{20'h0_0FF6, 20'h8_0088, 20'hC_8FB9, 20'h4_8071, 20'h3_8FF5,
             20'h1_0031, 20'h0_C0F5, 20'h0_40FA, 20'h0_EFF6, 20'h0_6000};
    idle(5);
    srst <= 1'h0;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h06);
    for (int i = 0; i < 10; i++) begin
      en <= rows[i][19:12];
      port_direction_bits <= rows[i][11:8];
      idle(2);
      #1 chk({4'h0, pin_oe}, {4'h0, rows[i][7:4]});
      chk({4'h0, pin_out & pin_oe}, {4'h0, rows[i][3:0]});
    end
    en <= 8'h00;
    wr(3'h0, 8'h80);
    rd(3'h0, 8'h80);
    chk({7'h00, overcurrent_enable}, 8'h01);
    // Reserved register in normal, then special mode
    wr(3'h2, 8'h5A);
    idle(2);
    #1 chk(factory_test, 8'h00);
    special_mode <= 1'h1;
    wr(3'h2, 8'h5A);
    idle(1);
    special_mode <= 1'h0;
    idle(1);
    #1 chk(factory_test, 8'h5A);
    // Input and data reads, input register ignores writes
    ext <= 4'h9;
    wr(3'h4, 8'hFF);
    idle(8);
    rd(3'h4, 8'h09);
    rd(3'h3, 8'h09);
    port_direction_bits <= 4'hF;
    idle(8);
    rd(3'h4, 8'h06);
    wr(3'h3, 8'h0C);
    rd(3'h3, 8'h0C);
    chk({4'h0, pin_out}, 8'h0C);
    port_direction_bits <= 4'h0;
    phy_rx_route <= 4'h8;
    idle(8);
    #1 chk({4'h0, tim_capture}, 8'h01);
    chk({4'h0, pin_sync}, 8'h09);
    // Level interrupt, edge select locked by first write
    wr(3'h1, 8'h40);
    wr(3'h1, 8'hC0);
    rd(3'h1, 8'h40);
    irq_pin_n <= 1'h0;
    idle(8);
    #1 chk({7'h00, irq_request}, 8'h01);
    irq_pin_n <= 1'h1;
    idle(8);
    #1 chk({7'h00, irq_request}, 8'h00);
    irq_pin_n <= 1'h0;
    wr(3'h1, 8'h00);
    idle(4);
    #1 chk({7'h00, irq_request}, 8'h00);
    // Edge mode written in special mode
    irq_pin_n <= 1'h1;
    special_mode <= 1'h1;
    wr(3'h1, 8'hC0);
    idle(1);
    special_mode <= 1'h0;
    rd(3'h1, 8'hC0);
    idle(8);
    #1 chk({7'h00, irq_request}, 8'h00);
    irq_pin_n <= 1'h0;
    idle(8);
    #1 chk({7'h00, irq_request}, 8'h01);
    irq_pin_n <= 1'h1;
    idle(8);
    #1 chk({7'h00, irq_request}, 8'h01);
    irq_service <= 1'h1;
    idle(1);
    irq_service <= 1'h0;
    idle(3);
    #1 chk({7'h00, irq_request}, 8'h00);
    // Second reset reopens the edge select
    srst <= 1'h1;
    idle(5);
    srst <= 1'h0;
    #1 chk({7'h00, overcurrent_enable}, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h1, 8'h80);
    rd(3'h1, 8'h80);
    rd(3'h7, 8'h00);
    results();
  end
endmodule : tb
